//--- core/bus_own_pkg.sv
`default_nettype none
package bus_own_pkg;
  // arbitration modes
  localparam logic MODE_TWO_WIRE = 1'h0;
  localparam logic MODE_THREE_WIRE = 1'h1;
  // reset values of the pin-facing outputs (active low pins, negated)
  localparam logic BD_N_RESET = 1'h1;
  localparam logic BR_N_RESET = 1'h1;
  localparam logic BUS_OE_N_RESET = 1'h1;
  localparam logic TS_RESET = 1'h0;
  typedef enum logic [1:0] {
    ST_RESET,
    ST_ALT_MASTER_OWNED,
    ST_IMPLICIT,
    ST_EXPLICIT
  } own_state_e;
endpackage
`default_nettype wire

//--- core/bus_own_fsm.sv
`default_nettype none
module bus_own_fsm (
  input wire logic CLK_I,
  input wire logic RESETN_I,
  input wire logic WDOG_RESET_I,
  input wire logic MODE_I,
  input wire logic BUS_GRANT_IN_N_I,
  input wire logic BUS_LOCK_BIT_I,
  input wire logic INTERNAL_BUS_REQUEST_I,
  input wire logic BURST_LAST_I,
  input wire logic TRANSFER_ACK_I,
  input wire logic TRANSFER_ERROR_ACK_I,
  output logic BUS_DRIVEN_OUT_N_O,
  output logic BUS_REQUEST_OUT_N_O,
  output logic BUS_OE_N_O,
  output logic TRANSFER_START_O,
  output logic BUSY_O,
  output bus_own_pkg::own_state_e STATE_O
);
  import bus_own_pkg::*;

  // ****************************************
  // reset release and input synchronisers
  // ****************************************
  logic rst_s1_r;
  logic rst_n;
  logic [3:0] sync1_r;
  logic [3:0] sync2_r;
  logic grant;
  logic mode_three;
  logic lock;
  logic wdog;
  logic ack_any;
  logic burst_last;

  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      rst_s1_r <= 1'h0;
      rst_n <= 1'h0;
    end else begin
      rst_s1_r <= 1'h1;
      rst_n <= rst_s1_r;
    end
  end

  // pins are asynchronous to this clock; acks and burst marker come from the
  // bus cycle engine on this clock and are used directly
  // the synchroniser wakes with grant negated, so nothing drives before the pin is seen
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r <= 4'h1;
      sync2_r <= 4'h1;
    end else begin
      sync1_r <= {MODE_I, BUS_LOCK_BIT_I, WDOG_RESET_I, BUS_GRANT_IN_N_I};
      sync2_r <= sync1_r;
    end
  end

  assign grant = ~sync2_r[0];
  assign wdog = sync2_r[1];
  assign lock = sync2_r[2];
  assign mode_three = (sync2_r[3] == MODE_THREE_WIRE);
  assign ack_any = TRANSFER_ACK_I | TRANSFER_ERROR_ACK_I;
  assign burst_last = BURST_LAST_I;

  // ****************************************
  // transfer progress
  // ****************************************
  logic busy_r;
  logic start_now;
  logic end_of_cycle;
  own_state_e state_r;
  own_state_e state_nxt;

  // acks outside a transfer are ignored, so a stray pulse cannot end a cycle
  // a cycle ends only on the acknowledge of the last transfer of a series, or on a watchdog reset
  assign end_of_cycle = busy_r & ack_any & burst_last;
  assign start_now = INTERNAL_BUS_REQUEST_I & ~busy_r & grant &
                     (state_r == ST_IMPLICIT || state_r == ST_EXPLICIT);

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      busy_r <= 1'h0;
    end else if (wdog) begin
      busy_r <= 1'h0;
    end else if (start_now) begin
      busy_r <= 1'h1;
    end else if (end_of_cycle) begin
      busy_r <= 1'h0;
    end
  end

  // ****************************************
  // ownership state machine
  // ****************************************
  // a start from alternate-master ownership waits one cycle in explicit
  // ownership, so the lines are already driven when the first transfer begins
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_RESET: begin
        state_nxt = grant ? ST_IMPLICIT : ST_ALT_MASTER_OWNED;
      end
      ST_IMPLICIT: begin
        if (!grant) begin
          state_nxt = ST_ALT_MASTER_OWNED;
        end else if (lock || INTERNAL_BUS_REQUEST_I) begin
          state_nxt = ST_EXPLICIT;
        end
      end
      ST_EXPLICIT: begin
        if (!grant && !lock) begin
          if (!busy_r || end_of_cycle) begin
            state_nxt = ST_ALT_MASTER_OWNED;
          end
        end
      end
      ST_ALT_MASTER_OWNED: begin
        if (grant) begin
          state_nxt = (lock || INTERNAL_BUS_REQUEST_I) ? ST_EXPLICIT : ST_IMPLICIT;
        end
      end
      default: begin
        state_nxt = ST_RESET;
      end
    endcase
  end

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_RESET;
    end else if (wdog) begin
      state_r <= ST_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ****************************************
  // pin outputs, all registered and always driven
  // ****************************************
  logic drive_nxt;
  logic ts_nxt;
  logic req_nxt;

  // bus-driven and bus drive follow the next state so they rise with a start from implicit ownership
  assign drive_nxt = ~wdog & (state_nxt == ST_EXPLICIT);
  // start only with a pending request; lock alone never starts a transfer
  assign ts_nxt = ~wdog & start_now & (state_nxt == ST_EXPLICIT);
  // request stands through the start cycle and drops once busy is seen, or as
  // soon as the core withdraws; it only says that the core wants the bus
  assign req_nxt = ~wdog & mode_three & INTERNAL_BUS_REQUEST_I & ~busy_r;

  // bus-driven and the shared bus enable switch together, so a released bus
  // never shows the driven indicator with floating lines, or the reverse
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      BUS_DRIVEN_OUT_N_O <= BD_N_RESET;
      BUS_OE_N_O <= BUS_OE_N_RESET;
    end else begin
      BUS_DRIVEN_OUT_N_O <= ~drive_nxt;
      BUS_OE_N_O <= ~drive_nxt;
    end
  end

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      TRANSFER_START_O <= TS_RESET;
    end else begin
      TRANSFER_START_O <= ts_nxt;
    end
  end

  // request and bus-driven are plain flops with a defined reset level; they are
  // never left floating and must not share a wired-or line with other masters
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      BUS_REQUEST_OUT_N_O <= BR_N_RESET;
    end else begin
      BUS_REQUEST_OUT_N_O <= ~req_nxt;
    end
  end

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      BUSY_O <= 1'h0;
    end else begin
      BUSY_O <= busy_r;
    end
  end

  // loaded from the same next-state value as the machine, so observers see
  // the ownership that the pins express in the same cycle
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      STATE_O <= ST_RESET;
    end else begin
      STATE_O <= wdog ? ST_RESET : state_nxt;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  // ownership states and bus drive
  a_release_idle: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (state_r != ST_EXPLICIT) |-> BUS_OE_N_O)
    else $error("bus driven outside explicit ownership");
  a_implicit_quiet: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (state_r == ST_IMPLICIT) |-> (BUS_DRIVEN_OUT_N_O && BUS_OE_N_O))
    else $error("implicit ownership drives the bus");
  a_explicit_drive: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (state_r == ST_EXPLICIT) |-> (!BUS_DRIVEN_OUT_N_O && !BUS_OE_N_O))
    else $error("explicit ownership without bus drive");
  a_grant_keeps: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (state_r == ST_EXPLICIT && grant && !wdog) |=> (state_r == ST_EXPLICIT && !BUS_DRIVEN_OUT_N_O))
    else $error("ownership dropped while granted");
  a_oe_with_bd: assert property (@(posedge CLK_I) disable iff (!rst_n)
    BUS_OE_N_O == BUS_DRIVEN_OUT_N_O)
    else $error("bus enable and bus driven disagree");
  a_state_mirror: assert property (@(posedge CLK_I) disable iff (!rst_n)
    STATE_O == state_r)
    else $error("state output differs from the machine");

  // state transitions
  a_wdog_reset: assert property (@(posedge CLK_I) disable iff (!rst_n)
    wdog |=> (state_r == ST_RESET))
    else $error("watchdog did not force reset");
  a_reset_exit: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (state_r == ST_RESET && !wdog) |=> (state_r == (grant ? ST_IMPLICIT : ST_ALT_MASTER_OWNED)))
    else $error("wrong exit from reset");
  a_implicit_loss: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (state_r == ST_IMPLICIT && !grant && !wdog) |=> (state_r == ST_ALT_MASTER_OWNED))
    else $error("implicit ownership kept without grant");
  a_implicit_stay: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (state_r == ST_IMPLICIT && grant && !lock && !INTERNAL_BUS_REQUEST_I && !wdog) |=> (state_r == ST_IMPLICIT))
    else $error("implicit ownership left without cause");
  a_implicit_lock: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (state_r == ST_IMPLICIT && grant && lock && !wdog) |=> (state_r == ST_EXPLICIT && !BUS_DRIVEN_OUT_N_O))
    else $error("lock did not take explicit ownership");
  a_am_wait: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (state_r == ST_ALT_MASTER_OWNED && !grant && !wdog) |=> (state_r == ST_ALT_MASTER_OWNED && BUS_DRIVEN_OUT_N_O))
    else $error("alternate-master ownership left without grant");
  a_am_grant_idle: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (state_r == ST_ALT_MASTER_OWNED && grant && !lock && !INTERNAL_BUS_REQUEST_I && !wdog) |=>
    (state_r == ST_IMPLICIT))
    else $error("idle grant did not give implicit ownership");
  a_am_grant_req: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (state_r == ST_ALT_MASTER_OWNED && grant && (lock || INTERNAL_BUS_REQUEST_I) && !wdog) |=>
    (state_r == ST_EXPLICIT && !BUS_DRIVEN_OUT_N_O))
    else $error("grant with demand did not give explicit ownership");

  // release rules
  a_hold_in_cycle: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (state_r == ST_EXPLICIT && busy_r && !end_of_cycle && !wdog) |=> (state_r == ST_EXPLICIT))
    else $error("bus released mid cycle");
  a_lock_keeps: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (state_r == ST_EXPLICIT && lock && !wdog) |=> (state_r == ST_EXPLICIT))
    else $error("bus released while locked");
  a_free_release: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (state_r == ST_EXPLICIT && !busy_r && !grant && !lock && !wdog) |=> (state_r == ST_ALT_MASTER_OWNED))
    else $error("idle bus kept after grant loss");
  a_release_on_end: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (state_r == ST_EXPLICIT && end_of_cycle && !grant && !lock && !wdog) |=>
    (state_r == ST_ALT_MASTER_OWNED && BUS_DRIVEN_OUT_N_O && BUS_OE_N_O))
    else $error("no release at end of cycle");

  // transfer start and termination
  a_ts_with_bd: assert property (@(posedge CLK_I) disable iff (!rst_n)
    TRANSFER_START_O |-> !BUS_DRIVEN_OUT_N_O)
    else $error("transfer start without bus driven");
  a_implicit_start: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (state_r == ST_IMPLICIT && grant && INTERNAL_BUS_REQUEST_I && !busy_r && !wdog) |=>
    (TRANSFER_START_O && !BUS_DRIVEN_OUT_N_O))
    else $error("request in implicit ownership did not start");
  a_start_needs_req: assert property (@(posedge CLK_I) disable iff (!rst_n)
    !INTERNAL_BUS_REQUEST_I |=> !TRANSFER_START_O)
    else $error("transfer started without a request");
  a_ts_pulse: assert property (@(posedge CLK_I) disable iff (!rst_n)
    TRANSFER_START_O |=> !TRANSFER_START_O)
    else $error("transfer start longer than one cycle");
  a_no_start_busy: assert property (@(posedge CLK_I) disable iff (!rst_n)
    busy_r |=> !TRANSFER_START_O)
    else $error("transfer started inside a cycle");
  a_burst_holds: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (busy_r && ack_any && !burst_last && !wdog) |=> busy_r)
    else $error("cycle ended before the last transfer");
  a_error_ends: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (busy_r && TRANSFER_ERROR_ACK_I && burst_last) |=> !busy_r)
    else $error("error acknowledge did not end the cycle");
  a_busy_follows: assert property (@(posedge CLK_I) disable iff (!rst_n)
    BUSY_O == $past(busy_r))
    else $error("busy output does not follow the cycle");

  // bus request
  a_req_two_wire: assert property (@(posedge CLK_I) disable iff (!rst_n)
    !mode_three |=> BUS_REQUEST_OUT_N_O)
    else $error("request asserted in two-wire mode");
  a_req_pending: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (mode_three && INTERNAL_BUS_REQUEST_I && !busy_r && !wdog) |=> !BUS_REQUEST_OUT_N_O)
    else $error("pending request not shown");
  a_req_through_ts: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (TRANSFER_START_O && $past(mode_three)) |-> !BUS_REQUEST_OUT_N_O)
    else $error("request dropped before the transfer started");
  a_req_withdrawn: assert property (@(posedge CLK_I) disable iff (!rst_n)
    !INTERNAL_BUS_REQUEST_I |=> BUS_REQUEST_OUT_N_O)
    else $error("request kept after withdrawal");

  // ****************************************
  // cover points
  // ****************************************
  c_lock_entry: cover property (@(posedge CLK_I) disable iff (!rst_n)
    state_r == ST_IMPLICIT && lock ##1 state_r == ST_EXPLICIT);
  c_request_entry: cover property (@(posedge CLK_I) disable iff (!rst_n)
    state_r == ST_IMPLICIT && INTERNAL_BUS_REQUEST_I ##1 TRANSFER_START_O);
  c_released: cover property (@(posedge CLK_I) disable iff (!rst_n)
    state_r == ST_EXPLICIT && busy_r ##1 state_r == ST_ALT_MASTER_OWNED);
  c_three_wire_req: cover property (@(posedge CLK_I) disable iff (!rst_n)
    !BUS_REQUEST_OUT_N_O ##[1:8] TRANSFER_START_O);
  c_error_end: cover property (@(posedge CLK_I) disable iff (!rst_n)
    busy_r && TRANSFER_ERROR_ACK_I && burst_last ##1 !busy_r);
endmodule
`default_nettype wire

//--- tb/bus_arb_model.sv
`default_nettype none
module bus_arb_model (
  input wire logic clk_i,
  input wire logic alt_hold_i,
  input wire logic bd_n_i,
  output logic grant_n_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic alt_busy_r = 1'b1;
  logic grant_n_r = 1'b1;
  assign grant_n_o = grant_n_r;
  // the grant waits a cycle after the alternate master lets go, so its drivers are off
  always @(posedge clk_i) begin
    alt_busy_r <= #5 alt_hold_i & bd_n_i;
    grant_n_r <= #5 alt_hold_i | alt_busy_r;
  end
endmodule
`default_nettype wire

//--- tb/external_bus_ownership_fsm_tb_top.sv
`default_nettype none
module external_bus_ownership_fsm_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import bus_own_pkg::*;
  logic clk = 0, rstn = 0, wdog = 0, mode = 0, hold = 0, lock = 0, req = 0, last = 0, ack = 0, eack = 0;
  logic bd_n, br_n, oe_n, ts, busy, grant_n;
  own_state_e st;
  int err_total = 0;
  int n_compared = 0;
  always #25 clk = ~clk;
  bus_arb_model arb (.clk_i(clk), .alt_hold_i(hold), .bd_n_i(bd_n), .grant_n_o(grant_n));
  bus_own_fsm dut (.CLK_I(clk), .RESETN_I(rstn), .WDOG_RESET_I(wdog), .MODE_I(mode),
    .BUS_GRANT_IN_N_I(grant_n), .BUS_LOCK_BIT_I(lock), .INTERNAL_BUS_REQUEST_I(req),
    .BURST_LAST_I(last), .TRANSFER_ACK_I(ack), .TRANSFER_ERROR_ACK_I(eack),
    .BUS_DRIVEN_OUT_N_O(bd_n), .BUS_REQUEST_OUT_N_O(br_n), .BUS_OE_N_O(oe_n),
    .TRANSFER_START_O(ts), .BUSY_O(busy), .STATE_O(st));
  function automatic logic [1:0] pins(own_state_e s);
    return (s == ST_EXPLICIT) ? 2'b00 : 2'b11;
  endfunction
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask
  task automatic to_state(input own_state_e s);
    for (int i = 0; i < 40 && st !== s; i++) cyc(1);
    chk(st, s);
    chk({bd_n, oe_n}, pins(s));
  endtask
  task automatic xfer(input int nb, input bit drop);
    req = 1;
    for (int i = 0; i < 40 && ts !== 1'b1; i++) cyc(1);
    chk({ts, bd_n, oe_n}, 3'b100);
    req = 0;
    for (int i = 0; i < nb; i++) begin
      if (drop) hold = 1;
      cyc(2 + $urandom_range(2));
      chk(busy, 1'b1);
      last = (i == nb - 1);
      {ack, eack} = $urandom_range(1) ? 2'b10 : 2'b01;
      cyc(1);
      {ack, eack} = 2'b00;
      last = 0;
      if (i < nb - 1) chk(st, ST_EXPLICIT);
    end
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #200us;
    err_total++;
    finish_test();
  end
  initial begin
    void'($urandom(32'h5167));
    cyc(8);
    chk({bd_n, br_n, oe_n, ts}, 4'hE);
    cyc(8);
    rstn = 1;
    to_state(ST_IMPLICIT);
    $display("test reset exit done");
    for (int k = 0; k < 4; k++) begin
      xfer(2 + $urandom_range(1), k[0]);
      if (k[0]) begin
        to_state(ST_ALT_MASTER_OWNED);
        hold = 0;
        to_state(ST_IMPLICIT);
      end else begin
        cyc(4);
        chk({st, bd_n, oe_n}, {ST_EXPLICIT, 2'b00});
        chk({br_n, busy}, 2'b10);
      end
    end
    $display("test transfers done");
    wdog = 1;
    cyc(4);
    chk({st, bd_n, oe_n}, {ST_RESET, 2'b11});
    wdog = 0;
    to_state(ST_IMPLICIT);
    lock = 1;
    to_state(ST_EXPLICIT);
    chk(ts, 1'b0);
    hold = 1;
    cyc(6);
    chk({st, bd_n}, {ST_EXPLICIT, 1'b0});
    lock = 0;
    to_state(ST_ALT_MASTER_OWNED);
    $display("test lock done");
    mode = 1;
    req = 1;
    cyc(5);
    chk({br_n, ts, bd_n}, 3'b001);
    hold = 0;
    for (int i = 0; i < 40 && ts !== 1'b1; i++) cyc(1);
    chk({ts, bd_n, br_n}, 3'b100);
    req = 0;
    cyc(4);
    chk(br_n, 1'b1);
    $display("test three wire done");
    finish_test();
  end
endmodule
`default_nettype wire
